// >>> src/subset_decode_pkg.sv
// package: opcodes, flag layout and cycle counts for the instruction subset
package subset_decode_pkg;
  localparam logic [7:0] op_pop_accumulator      = 8'h86;
  localparam logic [7:0] op_pop_index_high       = 8'h8a;
  localparam logic [7:0] op_return_from_interrupt = 8'h80;
  localparam logic [7:0] op_return_from_sub      = 8'h81;
  localparam logic [7:0] op_rotate_left_acc      = 8'h49;
  localparam logic [7:0] op_rotate_left_index    = 8'h59;
  localparam logic [7:0] op_rotate_right_acc     = 8'h46;
  localparam logic [7:0] op_rotate_right_index   = 8'h56;
  localparam logic [7:0] op_subtract_with_borrow = 8'ha2;
  localparam logic [7:0] op_test_acc_zero        = 8'h4d;
  localparam logic [7:0] op_test_index_zero      = 8'h5d;
  localparam logic [7:0] op_stop                 = 8'h8e;
  localparam logic [7:0] op_wait                 = 8'h8f;
  // condition code bit positions
  localparam int cc_c = 0;
  localparam int cc_z = 1;
  localparam int cc_n = 2;
  localparam int cc_i = 3;
  localparam int cc_h = 4;
  localparam int cc_v = 7;
  localparam logic [7:0] cc_reset = 8'h68;
  localparam logic [7:0] sp_reset = 8'hff;
  localparam logic [7:0] sp_step  = 8'h01;
  localparam logic [3:0] cyc_return_int = 4'h7;
  localparam logic [3:0] cyc_rts  = 4'h4;
  localparam logic [3:0] cyc_pull = 4'h2;
  localparam logic [3:0] cyc_sub_borrow = 4'h2;
  localparam logic [3:0] cyc_one  = 4'h1;
  // index of the last byte pulled by each stack-reading instruction
  localparam logic [2:0] pull_last_int = 3'h4;
  localparam logic [2:0] pull_last_sub = 3'h1;
  localparam logic [2:0] pull_last_one = 3'h0;
  // architectural state seen by the rest of the core
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx_low;
    logic [7:0] idx_high;
    logic [7:0] sp;
    logic [7:0] program_counter_high;
    logic [7:0] program_counter_low;
    logic [7:0] condition_codes;
  } arch_state_t;
endpackage

// >>> src/subset_decode.sv
// instruction subset decode and execute unit
//
// Behaviour
// - pop_accumulator/pop_index_high: increment sp, then load register; flags unchanged.
// - return_from_interrupt, 7 cycles: pull cc, a, x, pc high, pc low, sp up first.
// - return from subroutine, 4 cycles: pull pc high then low, sp up before each.
// - rotate left through carry on a or x; v, n, z, c updated in one cycle.
// - rotate right through carry on a or x; v, n, z, c updated.
// - subtract_with_borrow: a minus operand minus carry; v, n, z, c; two cycles.
// - test a or x against zero; clear v, set n and z; one cycle.
// - stop clears interrupt mask then halts; other flags unchanged.
// - wait clears interrupt mask then holds busy and waiting until an interrupt is pending.
`timescale 1ns/10ps
`default_nettype none
module subset_decode (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic                          op_valid,
  input  wire logic [7:0]                    opcode,
  input  wire logic [7:0]                    operand,
  input  wire logic [7:0]                    mem_rdata,
  input  wire logic                          irq_pending,
  output logic                               busy,
  output logic                               done,
  output logic                               mem_rd,
  output logic [7:0]                         mem_addr,
  output logic                               not_mine,
  output logic                               stopped,
  output logic                               waiting,
  output subset_decode_pkg::arch_state_t     state
);
  // halt serves both the subtract padding and a stop that never ends
  typedef enum logic [2:0] {s_idle, s_pull, s_data, s_halt, s_wait} fsm_t;

  fsm_t                              fsm;
  logic [7:0]                        opc;
  logic [3:0]                        cnt;
  logic [2:0]                        pull_idx;
  logic [2:0]                        pull_last;
  subset_decode_pkg::arch_state_t    next_state;
  logic [7:0]                        res;
  logic [7:0]                        cc_new;
  logic                              listed;

  // shared flag helper so rotates, subtract and test agree on n and z
  function automatic logic [7:0] nz(input logic [7:0] cc, input logic [7:0] r);
    logic [7:0] o;
    o = cc;
    o[subset_decode_pkg::cc_n] = r[7];
    o[subset_decode_pkg::cc_z] = (r == 8'h00);
    return o;
  endfunction

  // decode of the listed subset
  wire is_pull = (opcode == subset_decode_pkg::op_pop_accumulator) ||
                 (opcode == subset_decode_pkg::op_pop_index_high);
  wire is_return_int = (opcode == subset_decode_pkg::op_return_from_interrupt);
  wire is_rts  = (opcode == subset_decode_pkg::op_return_from_sub);
  wire is_rol  = (opcode == subset_decode_pkg::op_rotate_left_acc) ||
                 (opcode == subset_decode_pkg::op_rotate_left_index);
  wire is_ror  = (opcode == subset_decode_pkg::op_rotate_right_acc) ||
                 (opcode == subset_decode_pkg::op_rotate_right_index);
  wire is_sub_borrow = (opcode == subset_decode_pkg::op_subtract_with_borrow);
  wire is_tst  = (opcode == subset_decode_pkg::op_test_acc_zero) ||
                 (opcode == subset_decode_pkg::op_test_index_zero);
  wire is_stop = (opcode == subset_decode_pkg::op_stop);
  wire is_wait = (opcode == subset_decode_pkg::op_wait);
  // rotates and tests pick their register from the opcode row
  wire on_idx  = opcode[4]; // 5x rows address the index register
  wire [7:0] src = on_idx ? state.idx_low : state.acc;
  wire       c_in = state.condition_codes[subset_decode_pkg::cc_c];
  // borrow out of the 9-bit difference becomes the carry flag
  wire [8:0] diff = {1'b0, state.acc} - {1'b0, operand} - {8'h00, c_in};
  wire [7:0] sp_up = state.sp + subset_decode_pkg::sp_step;
  // accepted only from idle, so op_valid is ignored while busy
  wire       start = clk_en && op_valid && (fsm == s_idle);

  // listed gates everything this block may change
  assign listed = is_pull | is_return_int | is_rts | is_rol | is_ror | is_sub_borrow |
                  is_tst | is_stop | is_wait;

  // single-cycle datapath results for rotate, subtract and test
  always_comb begin
    res    = src;
    cc_new = state.condition_codes;
    if (is_rol) begin
      res = {src[6:0], c_in};
      cc_new = nz(cc_new, res);
      cc_new[subset_decode_pkg::cc_c] = src[7];
      cc_new[subset_decode_pkg::cc_v] = res[7] ^ src[7];
    end else if (is_ror) begin
      res = {c_in, src[7:1]};
      cc_new = nz(cc_new, res);
      cc_new[subset_decode_pkg::cc_c] = src[0];
      cc_new[subset_decode_pkg::cc_v] = res[7] ^ src[0];
    end else if (is_sub_borrow) begin
      res = diff[7:0];
      cc_new = nz(cc_new, res);
      cc_new[subset_decode_pkg::cc_c] = diff[8];
      cc_new[subset_decode_pkg::cc_v] = (state.acc[7] ^ operand[7]) & (state.acc[7] ^ res[7]);
    end else if (is_tst) begin
      cc_new = nz(cc_new, src);
      cc_new[subset_decode_pkg::cc_v] = 1'b0;
    end else if (is_stop || is_wait) begin
      cc_new[subset_decode_pkg::cc_i] = 1'b0;
    end
  end

  // next architectural state: unlisted opcodes leave it untouched
  always_comb begin
    next_state = state;
    if (start && (is_rol || is_ror || is_sub_borrow || is_tst || is_stop || is_wait)) begin
      next_state.condition_codes = cc_new;
      if ((is_rol || is_ror) && on_idx) next_state.idx_low = res;
      else if (is_rol || is_ror || is_sub_borrow) next_state.acc = res;
    end else if (fsm == s_pull) begin
      next_state.sp = sp_up;
    end else if (fsm == s_data) begin
      case (opc)
        subset_decode_pkg::op_pop_accumulator: next_state.acc = mem_rdata;
        subset_decode_pkg::op_pop_index_high:  next_state.idx_high = mem_rdata;
        subset_decode_pkg::op_return_from_sub:
          if (pull_idx == 3'd0) next_state.program_counter_high = mem_rdata;
          else next_state.program_counter_low = mem_rdata;
        subset_decode_pkg::op_return_from_interrupt:
          case (pull_idx)
            3'd0:    next_state.condition_codes = mem_rdata;
            3'd1:    next_state.acc = mem_rdata;
            3'd2:    next_state.idx_low = mem_rdata;
            3'd3:    next_state.program_counter_high = mem_rdata;
            default: next_state.program_counter_low = mem_rdata;
          endcase
        default: next_state = state;
      endcase
      // the next byte's stack step overlaps this load
      if (pull_idx != pull_last) next_state.sp = sp_up;
    end
  end

  // architectural registers; clk_en low freezes them with the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{8'h00, 8'h00, 8'h00, subset_decode_pkg::sp_reset, 8'h00, 8'h00,
                 subset_decode_pkg::cc_reset};
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // sequencer: the first pull spends a cycle on the stack step, later pulls
  // overlap the load of one byte with the read of the next so returns fit
  // their cycle budget; cnt pads any instruction that would finish early
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fsm <= s_idle; opc <= 8'h00; cnt <= 4'h0; pull_idx <= 3'd0; pull_last <= 3'd0;
      busy <= 1'b0; done <= 1'b0; mem_rd <= 1'b0; mem_addr <= 8'h00;
      not_mine <= 1'b0; stopped <= 1'b0; waiting <= 1'b0;
    end else if (clk_en) begin
      done     <= 1'b0;
      mem_rd   <= 1'b0;
      not_mine <= 1'b0;
      cnt      <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
      case (fsm)
        s_idle: if (op_valid) begin
          opc      <= opcode;
          pull_idx <= 3'd0;
          // unlisted opcodes only raise not_mine; the rest of the decoder owns them
          if (!listed) begin
            not_mine <= 1'b1;
          end else if (is_pull || is_return_int || is_rts) begin
            fsm  <= s_pull;
            busy <= 1'b1;
            pull_last <= is_return_int ? subset_decode_pkg::pull_last_int :
                         (is_rts ? subset_decode_pkg::pull_last_sub :
                          subset_decode_pkg::pull_last_one);
            cnt <= (is_return_int ? subset_decode_pkg::cyc_return_int :
                    is_rts ? subset_decode_pkg::cyc_rts : subset_decode_pkg::cyc_pull)
                   - subset_decode_pkg::cyc_one;
          end else if (is_sub_borrow) begin
            fsm <= s_halt; busy <= 1'b1;
            cnt <= subset_decode_pkg::cyc_sub_borrow - subset_decode_pkg::cyc_one;
          end else if (is_stop) begin
            fsm <= s_halt; busy <= 1'b1; stopped <= 1'b1; cnt <= 4'h0;
          end else if (is_wait) begin
            fsm <= s_wait; busy <= 1'b1; waiting <= 1'b1;
          end else begin
            done <= 1'b1;
          end
        end
        // first pull: step sp and read the byte it now points at
        s_pull: begin
          mem_rd   <= 1'b1;
          mem_addr <= sp_up;
          fsm      <= s_data;
        end
        s_data: begin
          if (pull_idx == pull_last) begin
            fsm <= (cnt > 4'h1) ? s_halt : s_idle;
            busy <= (cnt > 4'h1);
            done <= (cnt <= 4'h1);
          end else begin
            // read the next byte while this one loads
            mem_rd   <= 1'b1;
            mem_addr <= sp_up;
          end
          pull_idx <= pull_idx + 3'd1;
        end
        // stop halts for good; only reset or the chip leaves it
        s_halt: if (!stopped && cnt <= 4'h1) begin
          fsm <= s_idle; busy <= 1'b0; done <= 1'b1;
        end
        // busy stays high so the core issues nothing until an interrupt is pending
        s_wait: if (irq_pending) begin
          fsm <= s_idle; busy <= 1'b0; waiting <= 1'b0; done <= 1'b1;
        end
        default: fsm <= s_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/stack_memory_model.sv
// stack memory model answering the unit's pull reads
`timescale 1ns/10ps
`default_nettype none
module stack_memory_model #(
  parameter logic [7:0] key = 8'he6
) (
  input  wire logic       clk,
  input  wire logic       mem_rd,
  input  wire logic [7:0] mem_addr,
  output logic [7:0]      mem_rdata
);
  logic       rd_q;
  logic [7:0] addr_q;
  logic [7:0] noise = 8'h00;
  // byte is also held for the cycle after the read
  always @(posedge clk) begin
    rd_q   <= mem_rd;
    addr_q <= mem_addr;
    noise  <= noise + 8'h3b;
  end
  // a live read answers first, so back-to-back reads never see the byte
  // before; outside a read and the cycle after it the bus churns, so a stale byte never looks valid
  assign mem_rdata = mem_rd ? (mem_addr ^ key) : rd_q ? (addr_q ^ key) : noise;
endmodule
`default_nettype wire

// >>> tb/subset_decode_asserts.sv
// concurrent checks on the instruction subset unit ports
`timescale 1ns/10ps
`default_nettype none
module subset_decode_asserts (
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic                           clk_en,
  input wire logic                           op_valid,
  input wire logic [7:0]                     opcode,
  input wire logic [7:0]                     operand,
  input wire logic                           busy,
  input wire logic                           done,
  input wire logic                           mem_rd,
  input wire logic [7:0]                     mem_addr,
  input wire logic                           not_mine,
  input wire logic                           waiting,
  input wire subset_decode_pkg::arch_state_t state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic                           take;
  logic [7:0]                     op_q;
  logic [7:0]                     opd_q;
  subset_decode_pkg::arch_state_t s;
  assign take = clk_en && op_valid && !busy;
  // snapshot at acceptance so each result is judged against its cause
  always_ff @(posedge clk) begin
    if (take) begin
      op_q  <= opcode;
      opd_q <= operand;
      s     <= state;
    end
  end
  sequence sub_take;
    take && opcode == 8'ha2;
  endsequence
  sequence fin(logic [7:0] op);
    done && op_q == op;
  endsequence
  sequence int_return_take;
    take && opcode == 8'h80;
  endsequence
  sequence sub_return_take;
    take && opcode == 8'h81;
  endsequence
  chk_return_cycles: assert property (int_return_take |=> !done [*6] ##1 done)
    else $error("interrupt return not seven cycles");
  chk_sub_return_cycles: assert property (sub_return_take |=> !done [*3] ##1 done)
    else $error("subroutine return not four cycles");
  chk_pop_address: assert property (mem_rd |-> mem_addr == state.sp)
    else $error("pull read not at incremented stack pointer");
  chk_pull_flags: assert property ((fin(8'h86) or fin(8'h8a)) |-> state.sp == s.sp + 8'h01 && state.condition_codes == s.condition_codes)
    else $error("pull moved flags or stack wrongly");
  chk_return_depth: assert property (fin(8'h80) |-> state.sp == s.sp + 8'h05)
    else $error("interrupt return stack depth wrong");
  chk_rts_flags: assert property (fin(8'h81) |-> state.sp == s.sp + 8'h02 && state.condition_codes == s.condition_codes)
    else $error("subroutine return stack or flags wrong");
  chk_single_cycle: assert property (take && opcode inside {8'h49, 8'h59, 8'h46, 8'h56, 8'h4d, 8'h5d} |=> done)
    else $error("single cycle op late");
  chk_rol_acc: assert property (fin(8'h49) |-> state.acc == {s.acc[6:0], s.condition_codes[0]} && state.condition_codes[0] == s.acc[7])
    else $error("left rotate result wrong");
  chk_ror_index: assert property (fin(8'h56) |-> state.idx_low == {s.condition_codes[0], s.idx_low[7:1]} && state.condition_codes[0] == s.idx_low[0])
    else $error("right rotate result wrong");
  chk_sub_latency: assert property (sub_take |-> ##[1:2] done)
    else $error("subtract did not finish");
  chk_sub_result: assert property (fin(8'ha2) |-> state.acc == s.acc - opd_q - {7'h00, s.condition_codes[0]})
    else $error("subtract result wrong");
  chk_test_flags: assert property (fin(8'h4d) |-> state.condition_codes[7:6] == {1'b0, s.condition_codes[6]} && state.condition_codes[2] == s.acc[7] && state.condition_codes[1] == (s.acc == 8'h00))
    else $error("test flags wrong");
  chk_wait_mask: assert property ($rose(waiting) |-> !state.condition_codes[3])
    else $error("wait left mask set");
  chk_foreign_quiet: assert property (not_mine |-> state == s)
    else $error("foreign opcode changed state");
endmodule
bind subset_decode subset_decode_asserts i_chk (.clk(clk), .rst(rst), .clk_en(clk_en),
  .op_valid(op_valid), .opcode(opcode), .operand(operand), .busy(busy), .done(done),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .not_mine(not_mine), .waiting(waiting), .state(state));
`default_nettype wire

// >>> tb/subset_decode_bench.sv
// self-checking bench for the instruction subset unit
`timescale 1ns/10ps
`default_nettype none
module subset_decode_bench;
  logic                           clk, rst, clk_en, op_valid, irq_pending;
  logic [7:0]                     opcode, operand, mem_rdata, mem_addr;
  logic                           busy, done, mem_rd, not_mine, stopped, waiting;
  subset_decode_pkg::arch_state_t state;
  int                             error_cnt = 0;
  int                             total_checks = 0;
  int                             last_cycles = 0;
  subset_decode i_subset_decode (.clk(clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .opcode(opcode), .operand(operand), .mem_rdata(mem_rdata), .irq_pending(irq_pending),
    .busy(busy), .done(done), .mem_rd(mem_rd), .mem_addr(mem_addr), .not_mine(not_mine),
    .stopped(stopped), .waiting(waiting), .state(state));
  stack_memory_model i_stack_memory_model (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, dropped after its edge; bounded wait for any completion sign
  task automatic issue(input logic [7:0] opc, input logic [7:0] opd);
    @(negedge clk);
    op_valid = 1'b1;
    opcode = opc;
    operand = opd;
    last_cycles = 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      op_valid = 1'b0;
      if ((done | not_mine | waiting | stopped) === 1'b1) begin
        last_cycles = i + 1; // cycles from acceptance to the completion sign
        break;
      end
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    cmp(state.sp, 8'hff);
    cmp(state.condition_codes, 8'h68);
    cmp({2'b00, busy, done, mem_rd, not_mine, stopped, waiting}, 8'h00);
  endtask
  // reset leaves the mask set, so clearing it is visible
  task automatic t_wait();
    issue(8'h8f, 8'h00);
    cmp(state.condition_codes, 8'h60);
    cmp({7'h00, waiting}, 8'h01);
    irq_pending = 1'b1;
    repeat (3) @(negedge clk);
    cmp({7'h00, waiting}, 8'h00);
    irq_pending = 1'b0;
  endtask
  // stack starts at ff so the first pull wraps to 00; memory holds addr ^ e6
  task automatic t_pulls();
    issue(8'h86, 8'h00);
    cmp(state.acc, 8'he6);
    cmp(state.condition_codes, 8'h60);
    issue(8'h8a, 8'h00);
    cmp(state.idx_high, 8'he7);
    cmp(state.sp, 8'h01);
  endtask
  task automatic t_returns();
    issue(8'h80, 8'h00);
    cmp(8'(last_cycles), 8'h07);
    cmp(state.condition_codes, 8'he4);
    cmp(state.acc, 8'he5);
    cmp(state.idx_low, 8'he2);
    cmp(state.program_counter_high, 8'he3);
    cmp(state.program_counter_low, 8'he0);
    issue(8'h81, 8'h00);
    cmp(8'(last_cycles), 8'h04);
    cmp(state.program_counter_high, 8'he1);
    cmp(state.program_counter_low, 8'hee);
    cmp(state.sp, 8'h08);
    cmp(state.condition_codes, 8'he4);
  endtask
  // chained so each rotate and the subtract consume the carry left by the op before
  task automatic t_arith();
    issue(8'h49, 8'h00);
    cmp(8'(last_cycles), 8'h01);
    cmp(state.acc, 8'hca);
    cmp(state.condition_codes, 8'h65);
    issue(8'ha2, 8'hcb);
    cmp(8'(last_cycles), 8'h02);
    cmp(state.acc, 8'hfe);
    cmp(state.condition_codes, 8'h65);
    issue(8'h56, 8'h00);
    cmp(state.idx_low, 8'hf1);
    cmp(state.condition_codes, 8'he4);
    issue(8'h46, 8'h00);
    cmp(8'(last_cycles), 8'h01);
    cmp(state.acc, 8'h7f);
    cmp(state.condition_codes, 8'h60);
    issue(8'h59, 8'h00);
    cmp(state.idx_low, 8'he2);
    cmp(state.condition_codes, 8'h65);
    issue(8'h5d, 8'h00);
    cmp(state.condition_codes, 8'h65);
    issue(8'h4d, 8'h00);
    cmp(8'(last_cycles), 8'h01);
    cmp(state.condition_codes, 8'h61);
    issue(8'h9d, 8'h00);
    cmp({state.acc, state.sp, state.condition_codes} == 24'h7f0861, 8'h01);
  endtask
  // after a halt a further request must leave the flags alone
  task automatic t_stop();
    do_reset();
    issue(8'h8e, 8'h00);
    cmp(8'(last_cycles), 8'h01);
    cmp(state.condition_codes, 8'h60);
    cmp({7'h00, stopped}, 8'h01);
    issue(8'h49, 8'h00);
    cmp(state.condition_codes, 8'h60);
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    op_valid = 1'b0;
    irq_pending = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
    do_reset();
    t_wait();
    t_pulls();
    t_returns();
    t_arith();
    t_stop();
    results();
  end
  // a few hundred cycles suffice; this cuts a hang short
  initial begin
    #20000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
